// >>> common/pct_defines.vh
// Timing, width and reset constants for the pot compensation tracker.
// Included by the tracker sources; definitions only.
`ifndef PCT_DEFINES_VH
`define PCT_DEFINES_VH

// Clock rate and derived hold and step timing
`define PCT_CLK_HZ          50000000
`define PCT_HOLD_US         1500
`define PCT_HOLD_CYCLES     ((`PCT_HOLD_US * (`PCT_CLK_HZ / 1000000)))
`define PCT_STEP_HZ         10000
`define PCT_STEP_CYCLES     (`PCT_CLK_HZ / `PCT_STEP_HZ)

// Wiper geometry
`define PCT_POS_WIDTH       6
`define PCT_POS_MAX         6'h3F
`define PCT_CAL_STEPS       7'h3F
`define PCT_OVF_LIMIT       7'h3F
`define PCT_POS_RESET       6'h00

`endif

// >>> src/pct_sync2.v
// Two-stage synchroniser for a single asynchronous level.
// Assumes the input is a pin outside the sys_clk domain.
`timescale 1ns/100ps
`default_nettype none
module pct_sync2 (
	// Clock and reset
	input  wire sys_clk,
	input  wire reset,
	// Level in and out
	input  wire async_in,
	output reg  sync_out
);
	reg stage1;

	always @(posedge sys_clk) begin
		if (reset) begin
			stage1   <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // pct_sync2
`default_nettype wire

// >>> src/pct_tracker.v
// Pot compensation tracker: steps an external up/down potentiometer until
// the comparator flips, and keeps a running wiper position count.
// Assumes the comparator and enable pins are asynchronous to sys_clk;
// host-side register access is reduced to plain ports.
`timescale 1ns/100ps
`default_nettype none
`include "pct_defines.vh"
module pct_tracker #(
	parameter POS_WIDTH   = `PCT_POS_WIDTH,
	parameter HOLD_CYCLES = `PCT_HOLD_CYCLES,
	parameter STEP_CYCLES = `PCT_STEP_CYCLES
) (
	// Clock and reset
	input  wire                 sys_clk,
	input  wire                 reset,
	// Comparator: high when sensed input is above half supply
	input  wire                 comp_above,
	// Enable pins and host virtual enables
	input  wire                 cal_enable_pin,
	input  wire                 track_enable_pin,
	input  wire                 cal_enable_host,
	input  wire                 track_enable_host,
	// Potentiometer control
	output reg                  pot_select_n,
	output reg                  pot_step,
	// Status to host
	output reg  [POS_WIDTH-1:0] running_position_counter,
	output reg                  out_of_range_flag,
	output wire                 busy
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [4:0] ST_IDLE  = 5'h01;
	localparam [4:0] ST_HOLD  = 5'h02;
	localparam [4:0] ST_STEP  = 5'h04;
	localparam [4:0] ST_SETTL = 5'h08;
	localparam [4:0] ST_DONE  = 5'h10;

	localparam [POS_WIDTH-1:0] POS_MAX = {POS_WIDTH{1'b1}};
	localparam [6:0] CAL_STEPS = `PCT_CAL_STEPS;
	localparam [6:0] OVF_LIMIT = `PCT_OVF_LIMIT;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	wire comp_s;
	wire cal_pin_s;
	wire trk_pin_s;

	pct_sync2 u_sync_comp (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in (comp_above),
		.sync_out (comp_s)
	);
	pct_sync2 u_sync_cal (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in (cal_enable_pin),
		.sync_out (cal_pin_s)
	);
	pct_sync2 u_sync_trk (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.async_in (track_enable_pin),
		.sync_out (trk_pin_s)
	);

	// ----------------------------------------
	// Enable arbitration
	// ----------------------------------------
	wire cal_req = cal_pin_s | cal_enable_host;
	wire trk_req = (trk_pin_s | track_enable_host) & ~cal_req;
	reg  cal_req_d;
	reg  trk_req_d;
	wire cal_start = cal_req & ~cal_req_d;
	wire trk_start = trk_req & ~trk_req_d;

	// ----------------------------------------
	// Comparator edge detect
	// ----------------------------------------
	reg  comp_d;
	wire comp_edge = comp_s ^ comp_d;

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------
	reg [4:0]  state;
	reg [4:0]  next_state;
	reg        adjust_enable_flop_a;  // calibration preset run in progress
	reg        adjust_enable_flop_b;  // tracking in progress
	reg [6:0]  calibration_oneshot;   // up pulses still to send
	reg        dir_up;
	reg [31:0] hold_cnt;
	reg [31:0] step_cnt;
	reg [6:0]  ovf_cnt;
	reg        stop_pending;

	assign busy = (state != ST_IDLE);

	// Threshold above input means count up
	wire count_direction_logic = ~comp_s;
	wire in_preset = adjust_enable_flop_a & (calibration_oneshot != 7'h00);
	// One-shot overrides direction during the preset run
	wire direction_select_logic = in_preset ? 1'b1 : count_direction_logic;

	// Step waveform: long high for up, short high for down (inverse duty)
	wire [31:0] high_len = dir_up ? (STEP_CYCLES - STEP_CYCLES / 4) : (STEP_CYCLES / 4);
	wire step_period_end = (step_cnt == STEP_CYCLES - 1);
	// A line still high from an up-direction hold cannot rise yet;
	// that first period only lowers it, and is neither sent nor counted
	wire step_rise = (state == ST_STEP) && (step_cnt == 32'h0) && !pot_step;
	wire pot_pulse_gate = step_rise;

	// Edges during the preset run are ignored; decrement phase stops on one
	wire calibrate_stop_logic = comp_edge & ~in_preset;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always @* begin
		next_state = state;
		case (state)
		ST_IDLE: begin
			if (cal_start | trk_start)
				next_state = ST_HOLD;
		end
		ST_HOLD: begin
			if (hold_cnt == HOLD_CYCLES - 1)
				next_state = ST_STEP;
		end
		ST_STEP: begin
			// Preset end first: an edge from the last up pulse must not end the run
			if (step_period_end && adjust_enable_flop_a &&
				calibration_oneshot == 7'h00)
				next_state = ST_SETTL;
			else if (step_period_end && (stop_pending || out_of_range_flag))
				next_state = ST_DONE;
		end
		ST_SETTL: begin
			next_state = ST_HOLD;
		end
		ST_DONE: begin
			if (!cal_req && !trk_req)
				next_state = ST_IDLE;
		end
		default: begin
			next_state = ST_IDLE;
		end
		endcase
	end

	// ----------------------------------------
	// Sequencer and pot outputs
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			state                <= ST_IDLE;
			cal_req_d            <= 1'b0;
			trk_req_d            <= 1'b0;
			comp_d               <= 1'b0;
			adjust_enable_flop_a <= 1'b0;
			adjust_enable_flop_b <= 1'b0;
			calibration_oneshot  <= 7'h00;
			dir_up               <= 1'b0;
			hold_cnt             <= 32'h0;
			step_cnt             <= 32'h0;
			stop_pending         <= 1'b0;
			pot_select_n         <= 1'b1;
			pot_step             <= 1'b0;
		end else begin
			state     <= next_state;
			cal_req_d <= cal_req;
			trk_req_d <= trk_req;
			comp_d    <= comp_s;
			case (state)
			ST_IDLE: begin
				pot_select_n <= 1'b1;
				pot_step     <= comp_s;
				stop_pending <= 1'b0;
				hold_cnt     <= 32'h0;
				step_cnt     <= 32'h0;
				if (cal_start) begin
					adjust_enable_flop_a <= 1'b1;
					adjust_enable_flop_b <= 1'b0;
					calibration_oneshot  <= CAL_STEPS;
				end else if (trk_start) begin
					adjust_enable_flop_a <= 1'b0;
					adjust_enable_flop_b <= 1'b1;
				end
			end
			ST_HOLD: begin
				// Direction sits on the step line before select falls
				pot_select_n <= 1'b1;
				dir_up       <= direction_select_logic;
				pot_step     <= direction_select_logic;
				hold_cnt     <= hold_cnt + 32'h1;
				step_cnt     <= 32'h0;
				stop_pending <= 1'b0;
				if (hold_cnt == HOLD_CYCLES - 1)
					pot_select_n <= 1'b0;
				// Pin requests lag host ones by the synchroniser; a calibration
				// edge early in the hold still overrides a tracking start
				if (cal_start && hold_cnt < 32'h4) begin
					adjust_enable_flop_a <= 1'b1;
					adjust_enable_flop_b <= 1'b0;
					calibration_oneshot  <= CAL_STEPS;
				end
			end
			ST_STEP: begin
				pot_select_n <= 1'b0;
				step_cnt     <= step_period_end ? 32'h0 : step_cnt + 32'h1;
				// Rise at the period start of each step, then fall at high_len
				if (step_cnt == 32'h0)
					pot_step <= 1'b1;
				else if (step_cnt == high_len)
					pot_step <= 1'b0;
				if (calibrate_stop_logic)
					stop_pending <= 1'b1;
				if (step_rise && in_preset)
					calibration_oneshot <= calibration_oneshot - 7'h01;
			end
			ST_SETTL: begin
				// Preset done: reselect so the pot latches the new direction
				pot_select_n         <= 1'b1;
				hold_cnt             <= 32'h0;
				// Search phase runs as a tracking pass from the loaded maximum
				adjust_enable_flop_a <= 1'b0;
				adjust_enable_flop_b <= 1'b1;
			end
			ST_DONE: begin
				pot_select_n         <= 1'b1;
				pot_step             <= comp_s;
				adjust_enable_flop_a <= 1'b0;
				adjust_enable_flop_b <= 1'b0;
			end
			default: begin
				pot_select_n <= 1'b1;
			end
			endcase
		end
	end

	// ----------------------------------------
	// Running position count and range flag
	// ----------------------------------------
	// Counter is never allowed to wrap, matching the saturating pot.
	always @(posedge sys_clk) begin
		if (reset) begin
			running_position_counter <= `PCT_POS_RESET;
			out_of_range_flag        <= 1'b0;
			ovf_cnt                  <= 7'h00;
		end else begin
			if (state == ST_IDLE && (cal_start | trk_start)) begin
				out_of_range_flag <= 1'b0;
				ovf_cnt           <= 7'h00;
			end else if (comp_edge) begin
				ovf_cnt <= 7'h00;
			end
			if (pot_pulse_gate) begin
				if (in_preset) begin
					running_position_counter <= POS_MAX;
				end else if (dir_up) begin
					if (ovf_cnt >= OVF_LIMIT || running_position_counter == POS_MAX)
						out_of_range_flag <= 1'b1;
					else begin
						running_position_counter <= running_position_counter + 1'b1;
						ovf_cnt <= ovf_cnt + 7'h01;
					end
				end else begin
					if (running_position_counter == {POS_WIDTH{1'b0}})
						out_of_range_flag <= 1'b1;
					else
						running_position_counter <= running_position_counter - 1'b1;
				end
			end
		end
	end

endmodule // pct_tracker
`default_nettype wire

// >>> bench/pct_tracker_sva.sv
// Port assertions for the pot compensation tracker.
// Assumes one clock and a sync active-high reset.
`timescale 1ns/100ps
`default_nettype none
module pct_tracker_sva #(
	parameter POS_WIDTH   = 6,
	parameter HOLD_CYCLES = 20
) (
	// Clock, reset, host enables
	input wire logic                 sys_clk,
	input wire logic                 reset,
	input wire logic                 comp_above,
	input wire logic                 cal_enable_host,
	input wire logic                 track_enable_host,
	// Outputs
	input wire logic                 pot_select_n,
	input wire logic                 pot_step,
	input wire logic [POS_WIDTH-1:0] running_position_counter,
	input wire logic                 busy
);
	logic [31:0] hold_cnt;
	logic        dir_up;
	logic        step_q;
	logic [3:0]  stab_cnt;
	always @(posedge sys_clk) begin
		if (reset || !busy || !pot_select_n)
			hold_cnt <= 32'h0;
		else
			hold_cnt <= hold_cnt + 32'h1;
		step_q <= pot_step;
		if (reset || !pot_select_n || pot_step != step_q)
			stab_cnt <= 4'h0;
		else if (stab_cnt != 4'hF)
			stab_cnt <= stab_cnt + 4'h1;
		if ($fell(pot_select_n))
			dir_up <= pot_step;
	end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);
	property p_select_idle;
		!busy |-> pot_select_n;
	endproperty
	a_select_idle: assert property (p_select_idle) else $error("select low when idle");
	property p_idle_follow;
		(!busy && $stable(comp_above))[*5] |-> pot_step == comp_above;
	endproperty
	a_idle_follow: assert property (p_idle_follow) else $error("idle step line wrong");
	property p_hold_dir;
		$fell(pot_select_n) |-> $stable(pot_step) && stab_cnt >= 4'h8;
	endproperty
	a_hold_dir: assert property (p_hold_dir) else $error("direction not held");
	property p_hold_len;
		$fell(pot_select_n) |-> hold_cnt >= HOLD_CYCLES - 1 && hold_cnt <= HOLD_CYCLES + 1;
	endproperty
	a_hold_len: assert property (p_hold_len) else $error("hold length wrong");
	property p_cal_start;
		$rose(cal_enable_host) && !busy |-> ##[1:2] busy;
	endproperty
	a_cal_start: assert property (p_cal_start) else $error("host calibrate ignored");
	property p_track_start;
		$rose(track_enable_host) && !cal_enable_host && !busy |-> ##[1:2] busy;
	endproperty
	a_track_start: assert property (p_track_start) else $error("host track ignored");
	property p_up_duty;
		$rose(pot_step) && !pot_select_n && dir_up |-> pot_step[*6] ##1 !pot_step;
	endproperty
	a_up_duty: assert property (p_up_duty) else $error("up pulse width wrong");
	property p_down_duty;
		$rose(pot_step) && !pot_select_n && !dir_up |-> pot_step[*2] ##1 !pot_step;
	endproperty
	a_down_duty: assert property (p_down_duty) else $error("down pulse width wrong");
	property p_count_step;
		$changed(running_position_counter) |-> !pot_select_n &&
			(running_position_counter == $past(running_position_counter) + 1'b1 ||
			running_position_counter == $past(running_position_counter) - 1'b1 ||
			&running_position_counter);
	endproperty
	a_count_step: assert property (p_count_step) else $error("count jumped");
endmodule // pct_tracker_sva
bind pct_tracker pct_tracker_sva #(.POS_WIDTH(POS_WIDTH), .HOLD_CYCLES(HOLD_CYCLES)) i_sva (
	.sys_clk(sys_clk), .reset(reset), .comp_above(comp_above),
	.cal_enable_host(cal_enable_host), .track_enable_host(track_enable_host),
	.pot_select_n(pot_select_n), .pot_step(pot_step),
	.running_position_counter(running_position_counter), .busy(busy));
`default_nettype wire

// >>> bench/pct_pot_model.sv
// Up/down pot with comparator against a balance point.
// Assumes select and step are registered on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module pct_pot_model (
	// Pot control
	input  wire logic       sys_clk,
	input  wire logic       pot_select_n,
	input  wire logic       pot_step,
	// Balance and comparator
	input  wire logic [6:0] balance_point,
	output var  logic [5:0] wiper,
	output wire logic       comp_above
);
	logic sel_q, step_q, up;
	// Power-up wiper is unknown to the tracker
	initial wiper = 6'h15;
	always @(posedge sys_clk) begin
		sel_q <= pot_select_n;
		step_q <= pot_step;
		if (sel_q && !pot_select_n)
			up <= pot_step;
		if (!pot_select_n && !step_q && pot_step) begin
			if (up && wiper != 6'h3F)
				wiper <= wiper + 6'h01;
			else if (!up && wiper != 6'h00)
				wiper <= wiper - 6'h01;
		end
	end
	assign comp_above = {1'b0, wiper} >= balance_point;
endmodule // pct_pot_model
`default_nettype wire

// >>> bench/pct_tracker_tb.sv
// Self-checking bench for the pot compensation tracker.
// Assumes the pot model and the bound checker beside it.
`timescale 1ns/100ps
`default_nettype none
module pct_tracker_tb;
	logic       sys_clk, reset, comp_above, pot_select_n, pot_step, flag, busy;
	logic       cal_pin, trk_pin, cal_host, trk_host;
	logic [5:0] pos, wiper;
	logic [6:0] bal;
	integer     num_errors, n_compared, seed, i, n;
	pct_tracker #(.HOLD_CYCLES(20), .STEP_CYCLES(8)) i_pct_tracker (
		.sys_clk(sys_clk), .reset(reset), .comp_above(comp_above),
		.cal_enable_pin(cal_pin), .track_enable_pin(trk_pin),
		.cal_enable_host(cal_host), .track_enable_host(trk_host),
		.pot_select_n(pot_select_n), .pot_step(pot_step),
		.running_position_counter(pos), .out_of_range_flag(flag), .busy(busy));
	pct_pot_model i_pct_pot_model (.sys_clk(sys_clk), .pot_select_n(pot_select_n),
		.pot_step(pot_step), .balance_point(bal), .wiper(wiper), .comp_above(comp_above));
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	function automatic logic [6:0] exp_pos(input logic up, input logic [6:0] t);
		if (t == 7'h0) return 7'h0;
		if (t > 7'h3F) return 7'h3F;
		return up ? t : t - 7'h1;
	endfunction
	function automatic logic exp_oob(input logic [6:0] t);
		return t == 7'h0 || t > 7'h3F;
	endfunction
	task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Kind: 0/1 calibrate pin/host, 2/3 track pin/host, 4 both
	// ----------------------------------------
	task automatic run(input int kind, input logic [6:0] t);
		logic [6:0] e;
		int quiet;
		@(negedge sys_clk);
		bal = t;
		e = exp_pos((kind == 2 || kind == 3) && {1'b0, wiper} < t, t);
		cal_pin = kind == 0 || kind == 4;
		cal_host = kind == 1;
		trk_pin = kind == 2;
		trk_host = kind == 3 || kind == 4;
		quiet = 0;
		// Flag is sticky from the last run until the new start clears it
		for (n = 0; n < 8 && busy !== 1'b1; n++)
			@(negedge sys_clk);
		check("start", 7'h1, {6'h0, busy});
		for (n = 0; n < 3000 && quiet < 60 && !(exp_oob(t) && flag === 1'b1); n++) begin
			@(negedge sys_clk);
			quiet = (busy === 1'b1 && pot_select_n === 1'b1) ? quiet + 1 : 0;
		end
		check("position", e, {1'b0, pos});
		check("count", {1'b0, wiper}, {1'b0, pos});
		check("flag", {6'h0, exp_oob(t)}, {6'h0, flag});
		{cal_pin, cal_host, trk_pin, trk_host} = 4'h0;
		repeat (20) @(negedge sys_clk);
		check("busy", 7'h0, {6'h0, busy});
		check("select", 7'h1, {6'h0, pot_select_n});
		$display("test kind %0d target %0d done", kind, t);
	endtask
	initial begin
		seed = 32'h858a;
		num_errors = 0;
		n_compared = 0;
		{cal_pin, cal_host, trk_pin, trk_host} = 4'h0;
		bal = 7'h20;
		reset = 1'b1;
		repeat (16) @(negedge sys_clk);
		reset = 1'b0;
		check("reset count", 7'h0, {1'b0, pos});
		run(0, 7'h28);
		run(4, 7'h30);
		run(3, 7'h10);
		run(2, 7'h3F);
		for (i = 0; i < 8; i++)
			run($unsigned($random(seed)) % 4, 7'(1 + $unsigned($random(seed)) % 63));
		run(3, 7'h0);
		run(1, 7'h40);
		run(2, 7'h40);
		run(1, 7'h20);
		end_sim;
	end
	initial begin
		repeat (60000) @(posedge sys_clk);
		num_errors++;
		end_sim;
	end
endmodule // pct_tracker_tb
`default_nettype wire
